// ### rtl/pom_defs.svh
// Constants for the primary oscillator mode select block
`ifndef POM_DEFS_SVH
`define POM_DEFS_SVH
// ====================================================
// Timing
`define POM_CLK_PERIOD_NS 10
`define POM_EXT_START_NS 1500
`define POM_EXT_START_CYC (`POM_EXT_START_NS / `POM_CLK_PERIOD_NS)
`define POM_LOCK_US 2000
`define POM_LOCK_CYC (`POM_LOCK_US * 1000 / `POM_CLK_PERIOD_NS)
`define POM_TMR_W 18
`define POM_PER_W 16
// ====================================================
// Register offsets and fields
`define POM_ADDR_W 4
`define POM_DATA_W 8
`define POM_CTRL_OFS 4'h0
`define POM_STAT_OFS 4'h4
`define POM_CTRL_SEC_BIT 0
`define POM_CTRL_GPO_BIT 1
`define POM_CTRL_GOE_BIT 2
`define POM_CTRL_RST 8'h00
`define POM_GPIO_BIT_SIX 6
`define POM_SUBTICKS 2'h3
`endif

// ### rtl/pom_pkg.sv
// Types for the primary oscillator mode select block
package pom_pkg;
    // ====================================================
    // Oscillator modes in configuration field order
    typedef enum logic [2:0] {
        LOW_POWER_CRYSTAL_MODE,
        CRYSTAL_RESONATOR_MODE,
        HIGH_SPEED_CRYSTAL_MODE,
        HIGH_SPEED_MULTIPLIED_MODE,
        RESISTOR_CAPACITOR_MODE,
        RESISTOR_CAPACITOR_GPIO_MODE,
        EXT_CLOCK_INPUT_MODE,
        EXT_CLOCK_GPIO_PIN_MODE
    } pom_mode_t;
    // Start-up sequencer states
    typedef enum logic [1:0] {
        ST_WAIT,
        ST_RUN,
        ST_SECONDARY,
        ST_SLEEP
    } pom_state_t;
    // Status register layout
    typedef struct packed {
        logic gpioIn;
        logic secondaryActive;
        logic multiplierEnable;
        logic execEnable;
        logic [0:0] spare;
        pom_mode_t mode;
    } pom_status_t;
endpackage

// ### rtl/pom_osc_mode_select.sv
// Primary oscillator mode select, multiplier and start-up control
// Behaviour
// - Eight primary oscillator modes chosen by a three-bit config field.
// - Mode comes from nonvolatile config; software cannot change it.
// - Crystal modes also accept an external clock on the input pin.
// - RC mode drives the second pin with oscillator frequency over four.
// - RC-with-IO mode turns second pin into port bit six.
// - External clock modes take input pin and disable feedback path.
// - External clock modes wait at most 1.5 us after reset or wake.
// - External clock mode drives second pin with frequency over four.
// - External-clock-with-IO mode turns second pin into port bit six.
// - Multiplier mode makes internal clock four times the input frequency.
// - Multiplier only in high-speed family; otherwise clock is unmultiplied.
// - Multiplier state changes only at reset or secondary-clock round trip.
// - Lock timer holds execution until multiplied clock has locked.
// - Lock time-out lasts two milliseconds.
//
// Decided for this implementation: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`include "pom_defs.svh"
module pom_osc_mode_select import pom_pkg::*; #(
    parameter int unsigned LOCK_CYCLES = `POM_LOCK_CYC
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic [2:0] cfgMode,
    input wire logic primaryClockIn,
    input wire logic secondaryOscTick,
    input wire logic sleepActive,
    input wire logic secPinIn,
    output logic secPinOut,
    output logic secPinOe,
    output logic feedbackEnable,
    output logic sysClockTick,
    output logic [1:0] instrPhase,
    output logic execEnable,
    input wire logic [`POM_ADDR_W-1:0] regAddr,
    input wire logic [`POM_DATA_W-1:0] regWrData,
    input wire logic regWrStrobe,
    input wire logic regRdStrobe,
    output logic [`POM_DATA_W-1:0] regRdData
);
    localparam logic [`POM_TMR_W-1:0] EXT_START =
        `POM_TMR_W'(`POM_EXT_START_CYC);
    localparam logic [`POM_TMR_W-1:0] LOCK_CNT = `POM_TMR_W'(LOCK_CYCLES);

    // ====================================================
    // Mode helpers
    function automatic logic isExt(input pom_mode_t m);
        return m == EXT_CLOCK_INPUT_MODE || m == EXT_CLOCK_GPIO_PIN_MODE;
    endfunction
    function automatic logic isGpio(input pom_mode_t m);
        return m == RESISTOR_CAPACITOR_GPIO_MODE ||
               m == EXT_CLOCK_GPIO_PIN_MODE;
    endfunction
    function automatic logic isDiv4(input pom_mode_t m);
        return m == RESISTOR_CAPACITOR_MODE || m == EXT_CLOCK_INPUT_MODE;
    endfunction

    pom_mode_t mode_reg;
    pom_state_t state_reg;
    logic multEn_reg;
    logic [`POM_TMR_W-1:0] timer_reg;
    logic prevIn_reg;
    logic [`POM_PER_W-1:0] sinceEdge_reg;
    logic [`POM_PER_W-1:0] period_reg;
    logic [`POM_PER_W-1:0] quarterCnt_reg;
    logic [1:0] subTicks_reg;
    logic [1:0] phase_reg;
    logic [`POM_DATA_W-1:0] ctrl_reg;
    logic secOut_reg;
    logic secOe_reg;
    logic [`POM_DATA_W-1:0] rdData_reg;
    logic oscRise;
    logic multTick;
    logic [`POM_PER_W-1:0] quarter;
    logic secondarySel;
    logic prevSecSel_reg;
    logic prevSleep_reg;
    pom_status_t status;

    // ====================================================
    // Mode capture: strap taken only while reset is held
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            mode_reg <= pom_mode_t'(cfgMode);
        end
    end
    // No write path reaches mode_reg after reset

    // Feedback amplifier off for external clock sources
    assign feedbackEnable = !isExt(mode_reg);

    // ====================================================
    // Primary input edge detect; any mode may be externally driven
    assign oscRise = primaryClockIn && !prevIn_reg;
    // Tracks the pin in reset too, so release brings no false edge
    always_ff @(posedge sys_clk) begin
        prevIn_reg <= primaryClockIn;
    end

    // Period measurement of the primary oscillator
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            sinceEdge_reg <= '0;
            period_reg <= '0;
        end else if (oscRise) begin
            sinceEdge_reg <= `POM_PER_W'(1);
            period_reg <= sinceEdge_reg;
        end else if (sinceEdge_reg != '1) begin
            sinceEdge_reg <= sinceEdge_reg + `POM_PER_W'(1);
        end
    end

    // Times-four tick: edge plus three evenly spaced ticks
    assign quarter = (period_reg >> 2) == '0 ? `POM_PER_W'(1)
                                             : (period_reg >> 2);
    assign multTick = oscRise ||
        (subTicks_reg != `POM_SUBTICKS &&
         quarterCnt_reg == quarter - `POM_PER_W'(1));
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            quarterCnt_reg <= '0;
            subTicks_reg <= `POM_SUBTICKS;
        end else if (oscRise) begin
            quarterCnt_reg <= '0;
            subTicks_reg <= '0;
        end else if (multTick) begin
            quarterCnt_reg <= '0;
            subTicks_reg <= subTicks_reg + 2'h1;
        end else begin
            quarterCnt_reg <= quarterCnt_reg + `POM_PER_W'(1);
        end
    end

    // ====================================================
    // Start-up sequencer and lock timer
    assign secondarySel = ctrl_reg[`POM_CTRL_SEC_BIT];
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            prevSecSel_reg <= 1'b0;
            prevSleep_reg <= 1'b0;
        end else begin
            prevSecSel_reg <= secondarySel;
            prevSleep_reg <= sleepActive;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            state_reg <= ST_WAIT;
            timer_reg <= '0;
        end else begin
            unique case (state_reg)
                ST_WAIT: begin
                    timer_reg <= timer_reg + `POM_TMR_W'(1);
                    if (multEn_reg) begin
                        if (timer_reg >= LOCK_CNT - `POM_TMR_W'(1)) begin
                            state_reg <= ST_RUN;
                        end
                    end else if (isExt(mode_reg)) begin
                        if (timer_reg >= EXT_START - `POM_TMR_W'(1)) begin
                            state_reg <= ST_RUN;
                        end
                    end else begin
                        state_reg <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    timer_reg <= '0;
                    if (sleepActive) begin
                        state_reg <= ST_SLEEP;
                    end else if (secondarySel) begin
                        state_reg <= ST_SECONDARY;
                    end
                end
                ST_SECONDARY: begin
                    timer_reg <= '0;
                    if (!secondarySel) begin
                        state_reg <= ST_WAIT;
                    end
                end
                ST_SLEEP: begin
                    timer_reg <= '0;
                    if (!sleepActive) begin
                        state_reg <= ST_WAIT;
                    end
                end
            endcase
        end
    end

    // Multiplier enable loaded from the strap in reset, so the first
    // start-up already waits for lock; reloaded on return from secondary
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            multEn_reg <= pom_mode_t'(cfgMode) == HIGH_SPEED_MULTIPLIED_MODE;
        end else if (state_reg == ST_SECONDARY && !secondarySel) begin
            multEn_reg <= mode_reg == HIGH_SPEED_MULTIPLIED_MODE;
        end else if (state_reg == ST_WAIT && !prevIn_reg &&
                     timer_reg == '0 && !prevSecSel_reg &&
                     !prevSleep_reg) begin
            multEn_reg <= mode_reg == HIGH_SPEED_MULTIPLIED_MODE;
        end
    end

    assign execEnable = state_reg == ST_RUN || state_reg == ST_SECONDARY;

    // ====================================================
    // System tick source and instruction phase counter
    always_comb begin
        if (state_reg == ST_SLEEP) begin
            sysClockTick = 1'b0;
        end else if (state_reg == ST_SECONDARY) begin
            sysClockTick = secondaryOscTick;
        end else if (multEn_reg) begin
            sysClockTick = multTick;
        end else begin
            sysClockTick = oscRise;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            phase_reg <= 2'h0;
        end else if (sysClockTick) begin
            phase_reg <= phase_reg + 2'h1;
        end
    end
    assign instrPhase = phase_reg;

    // ====================================================
    // Second oscillator pin: divide-by-four or port bit six
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            secOut_reg <= 1'b0;
            secOe_reg <= 1'b0;
        end else if (isGpio(mode_reg)) begin
            secOut_reg <= ctrl_reg[`POM_CTRL_GPO_BIT];
            secOe_reg <= ctrl_reg[`POM_CTRL_GOE_BIT];
        end else if (isDiv4(mode_reg)) begin
            secOut_reg <= phase_reg[1] && state_reg != ST_SLEEP;
            secOe_reg <= 1'b1;
        end else begin
            secOut_reg <= 1'b0;
            secOe_reg <= 1'b0;
        end
    end
    assign secPinOut = secOut_reg;
    assign secPinOe = secOe_reg;

    // ====================================================
    // Register port
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            ctrl_reg <= `POM_CTRL_RST;
        end else if (regWrStrobe && regAddr == `POM_CTRL_OFS) begin
            ctrl_reg <= regWrData;
        end
    end

    always_comb begin
        status = '0;
        status.mode = mode_reg;
        status.execEnable = execEnable;
        status.multiplierEnable = multEn_reg;
        status.secondaryActive = state_reg == ST_SECONDARY;
        status.gpioIn = isGpio(mode_reg) && secPinIn;
    end

    // Read data stands one cycle after the strobe, zero otherwise
    always_ff @(posedge sys_clk) begin
        if (!reset_n) begin
            rdData_reg <= '0;
        end else if (regRdStrobe && regAddr == `POM_CTRL_OFS) begin
            rdData_reg <= ctrl_reg;
        end else if (regRdStrobe && regAddr == `POM_STAT_OFS) begin
            rdData_reg <= status;
        end else begin
            rdData_reg <= '0;
        end
    end
    assign regRdData = rdData_reg;

    // ====================================================
    // Assertions
    a_mode_fixed_run: assert property (@(posedge sys_clk)
        disable iff (!reset_n) $stable(mode_reg))
        else $error("mode changed while running");
    a_feedback_ext_off: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        feedbackEnable == (mode_reg < EXT_CLOCK_INPUT_MODE))
        else $error("feedback path wrong for mode");
    a_mult_only_hs: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        multEn_reg |-> mode_reg == HIGH_SPEED_MULTIPLIED_MODE)
        else $error("multiplier on outside high-speed mode");
    a_mult_run_stable: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        state_reg == ST_RUN ##1 state_reg == ST_RUN |-> $stable(multEn_reg))
        else $error("multiplier changed while running");
    a_ext_start_bound: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        $rose(state_reg == ST_WAIT) && isExt(mode_reg)
        |-> ##[1:151] state_reg == ST_RUN)
        else $error("external clock start-up too long");
    a_exec_lock_hold: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        $rose(execEnable) && multEn_reg |-> $past(timer_reg) + 1 >= LOCK_CNT)
        else $error("execution before lock time-out");
    a_div4_phase: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        $past(reset_n) && isDiv4(mode_reg) && $past(state_reg) != ST_SLEEP
        |-> secPinOut == $past(phase_reg[1]) && secPinOe)
        else $error("divide-by-four output not from phase");
    a_gpio_follow: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        isGpio(mode_reg) |=> secPinOe == $past(ctrl_reg[`POM_CTRL_GOE_BIT]))
        else $error("port bit six enable not followed");
    a_phase_step: assert property (@(posedge sys_clk)
        disable iff (!reset_n)
        sysClockTick |=> phase_reg == $past(phase_reg) + 2'h1)
        else $error("phase did not advance on tick");
    a_read_idle_zero: assert property (@(posedge sys_clk)
        disable iff (!reset_n) !regRdStrobe |=> regRdData == '0)
        else $error("read data outside read slot");

    c_lock_done: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $rose(execEnable) && multEn_reg);
    c_secondary_trip: cover property (@(posedge sys_clk)
        disable iff (!reset_n) $fell(state_reg == ST_SECONDARY));
    c_sleep_wake: cover property (@(posedge sys_clk) disable iff (!reset_n)
        $fell(state_reg == ST_SLEEP));
endmodule

// ### sim/pom_osc_source.sv
// External clock source model driving the primary oscillator input pin
`timescale 1ns/10ps
module pom_osc_source (
    input wire logic sys_clk,
    input wire logic runEnable,
    input wire logic [3:0] halfPeriod,
    output logic primaryClockIn
);
    logic [3:0] halfCnt;

    // ====================================================
    // Square wave
    initial begin
        primaryClockIn = 1'b0;
        halfCnt = 4'h0;
    end

    // Square wave on the input pin, frozen while the oscillator is off
    always @(posedge sys_clk) begin
        if (!runEnable) begin
            halfCnt <= 4'h0; // Oscillator stopped: line holds its level
        end else if (halfCnt >= halfPeriod - 4'h1) begin
            halfCnt <= 4'h0;
            primaryClockIn <= ~primaryClockIn; // Crystal stand-in
        end else begin
            halfCnt <= halfCnt + 4'h1;
        end
    end
endmodule

// ### sim/pom_osc_mode_select_tb.sv
// Self-checking testbench for the primary oscillator mode select block
`timescale 1ns/10ps
`include "pom_defs.svh"
module pom_osc_mode_select_tb import pom_pkg::*;;
    localparam int LockCyc = 20;
    logic sys_clk, reset_n, primaryClockIn, secondaryOscTick, sleepActive;
    logic secPinIn, secPinOut, secPinOe, feedbackEnable, sysClockTick;
    logic execEnable, regWrStrobe, regRdStrobe;
    logic [2:0] cfgMode;
    logic [1:0] instrPhase, phaseExp;
    logic [3:0] regAddr, halfPer;
    logic [7:0] regWrData, regRdData, rd;
    int failures, totalChecks, seed, n, e, t, s, expStart;
    bit isEc, isIo, isDiv, isMul;

    // ====================================================
    // Design, clock source and clock
    pom_osc_mode_select #(.LOCK_CYCLES(LockCyc)) uut (.sys_clk(sys_clk),
        .reset_n(reset_n), .cfgMode(cfgMode), .primaryClockIn(primaryClockIn),
        .secondaryOscTick(secondaryOscTick), .sleepActive(sleepActive),
        .secPinIn(secPinIn), .secPinOut(secPinOut), .secPinOe(secPinOe),
        .feedbackEnable(feedbackEnable), .sysClockTick(sysClockTick),
        .instrPhase(instrPhase), .execEnable(execEnable), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe),
        .regRdStrobe(regRdStrobe), .regRdData(regRdData));
    pom_osc_source src (.sys_clk(sys_clk), .runEnable(!sleepActive),
        .halfPeriod(halfPer), .primaryClockIn(primaryClockIn));

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    // ====================================================
    // Checking and bus tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        totalChecks++;
        if (got !== exp) begin
            failures++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic stop_test;
        if (failures == 0 && totalChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic regWr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        regWrStrobe <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge sys_clk);
        regWrStrobe <= 1'b0;
    endtask

    task automatic regRd(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        regRdStrobe <= 1'b1;
        regAddr <= a;
        @(posedge sys_clk);
        regRdStrobe <= 1'b0;
        #1 d = regRdData;
    endtask

    // Start-up cycles expected for a mode code
    function automatic int startCycles(input int m);
        return m == 3 ? LockCyc : m >= 6 ? `POM_EXT_START_CYC : 1;
    endfunction

    // Cycles until execution is allowed, bounded
    task automatic waitExec(output int cnt);
        cnt = 0;
        while (execEnable !== 1'b1 && cnt < 400) begin
            @(posedge sys_clk);
            #1 cnt++;
        end
    endtask

    // Oscillator edges, system ticks and divided-output rises in a window
    task automatic window(output int edges, output int ticks,
        output int rises);
        logic lastIn, lastOut;
        edges = 0;
        ticks = 0;
        rises = 0;
        @(posedge sys_clk);
        lastIn = primaryClockIn; // Same edge view as the design's detector
        lastOut = secPinOut;
        repeat (160) begin
            @(posedge sys_clk);
            edges += (primaryClockIn && !lastIn);
            ticks += (sysClockTick === 1'b1);
            rises += (secPinOut && !lastOut);
            lastIn = primaryClockIn;
            lastOut = secPinOut;
        end
    endtask

    // ====================================================
    // Background stimulus and phase counter model
    always @(posedge sys_clk) begin
        secondaryOscTick <= 1'($random(seed) & 1);
        if (reset_n === 1'b1) begin
            chk(instrPhase, phaseExp);
        end
        phaseExp <= !reset_n ? 2'h0 : phaseExp + {1'b0, sysClockTick};
    end

    initial begin
        #200000;
        failures++;
        stop_test;
    end

    // ====================================================
    // Main sequence: every mode in turn
    initial begin
        seed = 32'h2767;
        {reset_n, sleepActive, regWrStrobe, regRdStrobe, secondaryOscTick} = '0;
        {cfgMode, regAddr, regWrData, phaseExp} = '0;
        secPinIn = 1'b0;
        halfPer = 4'h4;
        for (int m = 0; m < 8; m++) begin
            isEc = m >= 6;
            isIo = (m == 5) || (m == 7);
            isDiv = (m == 4) || (m == 6);
            isMul = (m == 3);
            expStart = startCycles(m);
            @(posedge sys_clk);
            reset_n <= 1'b0;
            cfgMode <= m[2:0];
            halfPer <= 4'h4 + 4'($random(seed) & 3);
            secPinIn <= 1'($random(seed) & 1);
            repeat (6) @(posedge sys_clk);
            reset_n <= 1'b1;
            cfgMode <= 3'($random(seed)); // Strap ignored after release
            #1 chk(feedbackEnable, !isEc);
            waitExec(n);
            chk(n >= expStart && n <= expStart + 2, 1);
            regRd(`POM_STAT_OFS, rd);
            chk(rd[2:0], m);
            chk(rd[5], isMul);
            regWr(`POM_STAT_OFS, 8'($random(seed)));
            regWr(4'h9, 8'hFF);
            regRd(`POM_STAT_OFS, rd);
            chk(rd[2:0], m);
            regRd(4'h9, rd);
            chk(rd, 0);
            chk(secPinOe, isDiv);
            window(e, t, s);
            if (isMul) begin
                chk(t >= 4 * e - 3 && t <= 4 * e + 3, 1);
            end else begin
                chk(t, e);
            end
            if (isDiv) begin
                chk(s >= t / 4 - 1 && s <= t / 4 + 1, 1);
            end else begin
                chk(s, 0);
            end
            if (isIo) begin
                regWr(`POM_CTRL_OFS, 8'h06);
                @(posedge sys_clk);
                #1 chk({secPinOe, secPinOut}, 2'h3);
                regRd(`POM_STAT_OFS, rd);
                chk(rd[7], secPinIn);
            end
            regWr(`POM_CTRL_OFS, 8'h01);
            repeat (2) @(posedge sys_clk);
            repeat (20) begin
                @(posedge sys_clk);
                chk(sysClockTick, secondaryOscTick);
            end
            regRd(`POM_STAT_OFS, rd);
            chk(rd[6], 1);
            regRd(`POM_CTRL_OFS, rd);
            chk(rd, 8'h01);
            regWr(`POM_CTRL_OFS, 8'h00);
            repeat (2) @(posedge sys_clk);
            #1 waitExec(n);
            chk(n <= expStart + 3 && n + 3 >= expStart, 1);
            regRd(`POM_STAT_OFS, rd);
            chk(rd[5], isMul);
            @(posedge sys_clk);
            sleepActive <= 1'b1;
            repeat (10) begin
                @(posedge sys_clk);
                #1 chk(sysClockTick, 0);
            end
            @(posedge sys_clk);
            sleepActive <= 1'b0;
            waitExec(n);
            chk(n <= expStart + 3, 1);
        end
        stop_test;
    end
endmodule
